// *** rtl/crc_memory_scanner_debug_ctrl.sv ***
// memory scanner feeding the checksum unit, with debug freeze behaviour
`timescale 1ns/100ps
`include "scan_defines.svh"

module crc_memory_scanner_debug_ctrl
   import scan_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic [15:0] wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_we_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // debug logic and cpu
   input  wire dbg_evt_type dbg_evt_i,
   input  wire logic        cpu_free_i,
   output logic             cpu_stall_o,
   output logic             scan_frozen_o,
   // trigger sources and fuse pin
   input  wire logic [31:0] trig_src_i,
   input  wire logic        scanner_fuse_i,
   // program flash read port, data valid in the cycle of the read
   output logic             mem_rd_o,
   output logic      [23:0] mem_addr_o,
   input  wire logic [15:0] mem_data_i,
   // checksum unit
   input  wire logic        crc_ready_i,
   input  wire logic        crc_busy_i,
   input  wire logic [15:0] crc_shift_i,
   output logic             crc_load_o,
   output logic      [15:0] crc_data_o,
   output crc_cfg_type      crc_cfg_o
);

   ////////////////////////////////////////////////////////////////////////
   logic [1:0]     fuse_sync_r;
   logic [23:0]    start_addr_r;
   logic [23:0]    end_addr_r;
   logic           sc_en_r;
   logic           run_r;
   logic           inv_r;
   logic           intm_r;
   scan_mode_type  mode_r;
   logic [4:0]     tsel_r;
   logic [1:0]     md_r;
   logic [15:0]    cacc_r;
   logic [15:1]    taps_r;
   logic           cen_r;
   logic           cgo_r;
   logic           accm_r;
   logic           shiftm_r;
   logic [7:0]     ccon1_r;
   scan_state_type st_r;
   logic           last_r;
   logic           frz_r;
   logic           trig_prev_r;
   logic           fuse_ok;
   logic           scan_live;
   logic           crc_live;
   logic           bus_req;
   logic           wr_en;
   logic [11:0]    idx;
   logic           halt_blk;
   logic           issue;
   logic           last_iss;
   logic           trig_now;
   logic           stall_nxt;
   logic [23:0]    addr_nxt;

   function automatic logic [23:0] merge(input logic [23:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  s);
      logic [23:0] m;
      m = old;
      for (int b = 0; b < 3; b++) begin
         if (s[b]) begin
            m[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // fuse strap, two flops before use
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fuse_sync_r <= 2'b00;
      end else begin
         fuse_sync_r <= {fuse_sync_r[0], scanner_fuse_i};
      end
   end

   assign fuse_ok   = fuse_sync_r[1];
   // off bit matters only when the fuse makes the scanner available
   assign scan_live = fuse_ok & ~md_r[`MD_SCAN_OFF] & sc_en_r;
   assign crc_live  = ~md_r[`MD_CRC_OFF];
   assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_en     = bus_req & wb_we_i;
   assign idx       = wb_adr_i[13:2];

   ////////////////////////////////////////////////////////////////////////
   // scan sequencing
   // software breakpoint does not block: the access finishes first
   assign halt_blk = dbg_evt_i.ext_halt | dbg_evt_i.pc_break |
                     dbg_evt_i.data_break;
   assign trig_now = trig_src_i[tsel_r];
   assign addr_nxt = start_addr_r + `SCAN_STEP;
   assign last_iss = (start_addr_r == end_addr_r) |
                     (addr_nxt >= `SCAN_MEM_LIMIT);

   always_comb begin
      issue = scan_live & (st_r == ST_SCAN) & ~frz_r & ~halt_blk &
              crc_ready_i & cgo_r & cen_r & crc_live;
      if (mode_r != MODE_BURST) begin
         // cpu runs between single accesses
         issue = issue & ~mem_rd_o;
      end
      if (mode_r == MODE_PEEK) begin
         issue = issue & cpu_free_i;
      end
   end

   always_comb begin
      stall_nxt = 1'b0;
      case (mode_r)
         MODE_BURST: stall_nxt = scan_live & (st_r != ST_IDLE);
         MODE_CONC:  stall_nxt = issue;
         MODE_TRIG:  stall_nxt = issue;
         default:    stall_nxt = 1'b0;
      endcase
   end

   // freeze flag; a halt in the same cycle as an exit wins
   always_ff @(posedge clk_i) begin
      if (rst_i || !scan_live) begin
         frz_r <= 1'b0;
      end else if (halt_blk || dbg_evt_i.sw_break) begin
         frz_r <= 1'b1;
      end else if (dbg_evt_i.exit) begin
         frz_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !scan_live) begin
         st_r        <= ST_IDLE;
         last_r      <= 1'b0;
         trig_prev_r <= 1'b0;
      end else begin
         trig_prev_r <= trig_now;
         if (wr_en && idx == `IDX_SCAN_CTRL && wb_sel_i[0]) begin
            if (wb_dat_i[`SC_RUN] && !run_r) begin
               // run-bit write starts even while frozen; access waits
               if (mode_r == MODE_TRIG) begin
                  st_r <= ST_WAIT;
               end else begin
                  st_r <= ST_SCAN;
               end
               last_r <= 1'b0;
            end else if (!wb_dat_i[`SC_RUN]) begin
               st_r <= ST_IDLE;
            end
         end else begin
            case (st_r)
               ST_IDLE: begin
                  st_r <= ST_IDLE;
               end
               ST_WAIT: begin
                  if (trig_now && !trig_prev_r && !frz_r) begin
                     st_r <= ST_SCAN;
                  end
               end
               ST_SCAN: begin
                  if (!cgo_r || !cen_r) begin
                     st_r <= ST_IDLE;
                  end else if (issue && last_iss) begin
                     st_r   <= ST_IDLE;
                     last_r <= 1'b1;
                  end
               end
               default: begin
                  st_r <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // read port and data hand-off; an access in flight completes unless scan_live drops
   always_ff @(posedge clk_i) begin
      if (rst_i || !scan_live) begin
         mem_rd_o    <= 1'b0;
         mem_addr_o  <= 24'h000000;
         crc_load_o  <= 1'b0;
         cpu_stall_o <= 1'b0;
      end else begin
         mem_rd_o    <= issue;
         crc_load_o  <= mem_rd_o;
         cpu_stall_o <= stall_nxt;
         if (issue) begin
            mem_addr_o <= start_addr_r;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         scan_frozen_o <= 1'b0;
      end else begin
         scan_frozen_o <= frz_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // scanner registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_addr_r <= 24'h000000;
         end_addr_r   <= 24'h000000;
      end else if (wr_en && idx == `IDX_SCAN_START) begin
         start_addr_r <= merge(start_addr_r, wb_dat_i, wb_sel_i);
      end else if (wr_en && idx == `IDX_SCAN_END) begin
         end_addr_r <= merge(end_addr_r, wb_dat_i, wb_sel_i);
      end else if (issue && !last_iss) begin
         start_addr_r <= addr_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sc_en_r <= 1'b0;
         intm_r  <= 1'b0;
         mode_r  <= MODE_CONC;
         tsel_r  <= 5'h00;
      end else if (wr_en && idx == `IDX_SCAN_CTRL && wb_sel_i[0]) begin
         sc_en_r <= wb_dat_i[`SC_EN];
         intm_r  <= wb_dat_i[`SC_INTM];
         mode_r  <= scan_mode_type'(wb_dat_i[1:0]);
      end else if (wr_en && idx == `IDX_SCAN_TRIG && wb_sel_i[0]) begin
         tsel_r <= wb_dat_i[4:0];
      end
   end

   // run bit cleared by hardware at the end; abort marks the scan invalid
   always_ff @(posedge clk_i) begin
      if (rst_i || !scan_live) begin
         run_r <= 1'b0;
         inv_r <= `SC_INVALID_RST;
      end else if (wr_en && idx == `IDX_SCAN_CTRL && wb_sel_i[0]) begin
         run_r <= wb_dat_i[`SC_RUN];
         if (wb_dat_i[`SC_RUN]) begin
            inv_r <= 1'b0;
         end
      end else if (run_r && (!cgo_r || !cen_r)) begin
         run_r <= 1'b0;
         inv_r <= 1'b1;
      end else if (last_r && crc_load_o) begin
         run_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         md_r <= 2'b00;
      end else if (wr_en && idx == `IDX_MOD_DISABLE && wb_sel_i[0]) begin
         md_r <= wb_dat_i[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checksum unit registers, held at reset while the unit is off
   always_ff @(posedge clk_i) begin
      if (rst_i || !crc_live) begin
         cen_r      <= 1'b0;
         cgo_r      <= 1'b0;
         accm_r     <= 1'b0;
         shiftm_r   <= 1'b0;
         ccon1_r    <= 8'h00;
         cacc_r     <= 16'h0000;
         taps_r     <= 15'h0000;
         crc_data_o <= 16'h0000;
      end else begin
         if (wr_en && idx == `IDX_CRC_CTRL0 && wb_sel_i[0]) begin
            cen_r    <= wb_dat_i[`CC_EN];
            cgo_r    <= wb_dat_i[`CC_GO];
            accm_r   <= wb_dat_i[`CC_ACCM];
            shiftm_r <= wb_dat_i[`CC_SHIFTM];
         end
         if (wr_en && idx == `IDX_CRC_CTRL1 && wb_sel_i[0]) begin
            ccon1_r <= wb_dat_i[7:0];
         end
         if (wr_en && idx == `IDX_CRC_ACC) begin
            cacc_r <= 16'(merge({8'h00, cacc_r}, wb_dat_i, wb_sel_i));
         end
         if (wr_en && idx == `IDX_CRC_TAPS) begin
            taps_r <= 15'(merge({8'h00, taps_r, 1'b1}, wb_dat_i,
                                wb_sel_i) >> 1);
         end
         if (mem_rd_o) begin
            crc_data_o <= mem_data_i;
         end else if (wr_en && idx == `IDX_CRC_DATA) begin
            crc_data_o <= 16'(merge({8'h00, crc_data_o}, wb_dat_i,
                                    wb_sel_i));
         end
      end
   end

   assign crc_cfg_o = '{en: cen_r, go: cgo_r, accm: accm_r,
                        shiftm: shiftm_r, lengths: ccon1_r,
                        taps: {taps_r, 1'b1}, acc: cacc_r};

   ////////////////////////////////////////////////////////////////////////
   // bus answer: one wait state, reads never blocked by debug halt
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         if (!bus_req || wb_we_i) begin
            wb_dat_o <= 32'h0000_0000;
         end else if (idx == `IDX_SCAN_START) begin
            wb_dat_o <= {8'h00, start_addr_r};
         end else if (idx == `IDX_SCAN_END) begin
            wb_dat_o <= {8'h00, end_addr_r};
         end else if (idx == `IDX_SCAN_CTRL) begin
            wb_dat_o <= {24'h000000, sc_en_r, run_r,
                         (st_r != ST_IDLE) | mem_rd_o, inv_r, intm_r,
                         1'b0, mode_r};
         end else if (idx == `IDX_SCAN_TRIG) begin
            wb_dat_o <= {27'h0000000, tsel_r};
         end else if (idx == `IDX_MOD_DISABLE) begin
            wb_dat_o <= {30'h00000000, md_r};
         end else if (idx == `IDX_CRC_DATA) begin
            wb_dat_o <= {16'h0000, crc_data_o};
         end else if (idx == `IDX_CRC_ACC) begin
            wb_dat_o <= {16'h0000, cacc_r};
         end else if (idx == `IDX_CRC_SHIFT) begin
            wb_dat_o <= {16'h0000, crc_shift_i};
         end else if (idx == `IDX_CRC_TAPS) begin
            wb_dat_o <= {16'h0000, taps_r, 1'b1};
         end else if (idx == `IDX_CRC_CTRL0) begin
            wb_dat_o <= {24'h000000, cen_r, cgo_r, crc_busy_i, accm_r,
                         2'b00, shiftm_r, ~crc_ready_i};
         end else if (idx == `IDX_CRC_CTRL1) begin
            wb_dat_o <= {24'h000000, ccon1_r};
         end else begin
            wb_dat_o <= `UNMAPPED_DATA;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   frozen_no_read_a: assert property (frz_r |=> !mem_rd_o)
      else $error("read issued while frozen");
   frozen_addr_a: assert property (
      frz_r && !wr_en |=> $stable(start_addr_r))
      else $error("scan address moved while frozen");
   halt_defer_a: assert property (
      dbg_evt_i.ext_halt || dbg_evt_i.data_break |=> !mem_rd_o)
      else $error("access not deferred by halt");
   access_completes_a: assert property (
      mem_rd_o ##0 dbg_evt_i.sw_break |=> crc_load_o)
      else $error("access lost at software breakpoint");
   burst_stall_a: assert property (
      scan_live && mode_r == MODE_BURST && st_r == ST_SCAN
      |=> cpu_stall_o)
      else $error("burst without cpu stall");
   enable_reset_a: assert property (
      !sc_en_r |=> !run_r && st_r == ST_IDLE && !mem_rd_o)
      else $error("state kept with scanner disabled");
   fuse_gate_a: assert property (
      !fuse_ok |=> !mem_rd_o && !run_r)
      else $error("scanner active without fuse");
   crc_off_a: assert property (
      md_r[`MD_CRC_OFF] |=> !crc_cfg_o.en)
      else $error("checksum unit enabled while off");
   peek_free_a: assert property (
      mem_rd_o && mode_r == MODE_PEEK |-> $past(cpu_free_i))
      else $error("peek read in a busy cycle");
   bus_answer_a: assert property (
      bus_req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus request not answered in one cycle");

   burst_done_c: cover property (
      mode_r == MODE_BURST && last_r && crc_load_o);
   freeze_resume_c: cover property (frz_r ##1 !frz_r [*2] ##1 mem_rd_o);
   trig_start_c: cover property (st_r == ST_WAIT ##1 st_r == ST_SCAN);
   peek_read_c: cover property (mode_r == MODE_PEEK && mem_rd_o);

endmodule

// *** rtl/scan_defines.svh ***
// register indices, field positions, reset values and fixed values of the scanner
`ifndef SCAN_DEFINES_SVH
`define SCAN_DEFINES_SVH
// register indices; byte address is four times the index
`define IDX_SCAN_START   12'hf44
`define IDX_SCAN_END     12'hf47
`define IDX_SCAN_CTRL    12'hf4a
`define IDX_SCAN_TRIG    12'hf4b
`define IDX_CRC_DATA     12'hf6f
`define IDX_CRC_ACC      12'hf71
`define IDX_CRC_SHIFT    12'hf73
`define IDX_CRC_TAPS     12'hf75
`define IDX_CRC_CTRL0    12'hf77
`define IDX_CRC_CTRL1    12'hf78
`define IDX_MOD_DISABLE  12'hf40
// scan_control fields
`define SC_EN            7
`define SC_RUN           6
`define SC_INTM          3
// checksum_control_0 fields
`define CC_EN            7
`define CC_GO            6
`define CC_ACCM          4
`define CC_SHIFTM        1
// module_disable_register fields
`define MD_CRC_OFF       0
`define MD_SCAN_OFF      1
// reset and fixed values
`define SC_INVALID_RST   1'b1
`define UNMAPPED_DATA    32'h0000_0000
`define SCAN_STEP        24'h000002
`define SCAN_MEM_LIMIT   24'h010000
`endif

// *** rtl/scan_pkg.sv ***
// types shared by the memory scanner design
package scan_pkg;
   typedef enum logic [1:0] {
      MODE_CONC  = 2'b00,
      MODE_BURST = 2'b01,
      MODE_PEEK  = 2'b10,
      MODE_TRIG  = 2'b11
   } scan_mode_type;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_SCAN = 2'b10
   } scan_state_type;
   typedef struct packed {
      logic ext_halt;
      logic pc_break;
      logic data_break;
      logic sw_break;
      logic exit;
   } dbg_evt_type;
   typedef struct packed {
      logic        en;
      logic        go;
      logic        accm;
      logic        shiftm;
      logic [7:0]  lengths;
      logic [15:0] taps;
      logic [15:0] acc;
   } crc_cfg_type;
endpackage

// *** testbench/scan_partner.sv ***
// flash and checksum unit model facing the memory scanner
`timescale 1ns/100ps
module scan_partner #(
   parameter logic [15:0] SHIFT_VAL = 16'h3c5a
) (
   // clock
   input  wire logic        clk_i,
   // flash read port
   input  wire logic        mem_rd_i,
   input  wire logic [23:0] mem_addr_i,
   output logic      [15:0] mem_data_o,
   // checksum unit
   input  wire logic        crc_load_i,
   input  wire logic        hold_i,
   output logic             crc_ready_o,
   output logic             crc_busy_o,
   output logic      [15:0] crc_shift_o
);
   logic [15:0] last_r = 16'h0000;
   // outside the read cycle the word keeps changing
   always_comb begin
      if (mem_rd_i) begin
         mem_data_o = mem_addr_i[15:0] ^ 16'ha5c3;
      end else begin
         mem_data_o = ~last_r;
      end
   end
   always_ff @(posedge clk_i) begin
      last_r <= mem_data_o;
      crc_busy_o <= crc_load_i;
   end
   assign crc_ready_o = ~hold_i;
   assign crc_shift_o = SHIFT_VAL;
endmodule

// *** testbench/tb_crc_memory_scanner_debug_ctrl.sv ***
// self-checking bench for the memory scanner and its debug freeze
`timescale 1ns/100ps
`include "scan_defines.svh"
module tb_crc_memory_scanner_debug_ctrl
   import scan_pkg::*;
;
   localparam logic [15:0] SHIFT_VAL = 16'h3c5a;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [15:0] wb_adr_i = 16'h0000;
   logic [31:0] wb_dat_i = 32'h0;
   logic [3:0]  wb_sel_i = 4'h0;
   logic        wb_we_i = 1'b0;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   dbg_evt_type dbg_evt_i = 5'h00;
   logic        cpu_free_i = 1'b1;
   logic        cpu_stall_o;
   logic        scan_frozen_o;
   logic [31:0] trig_src_i = 32'h0;
   logic        scanner_fuse_i = 1'b1;
   logic        mem_rd_o;
   logic [23:0] mem_addr_o;
   logic [15:0] mem_data_i;
   logic        crc_ready_i;
   logic        crc_busy_i;
   logic [15:0] crc_shift_i;
   logic        crc_load_o;
   logic [15:0] crc_data_o;
   crc_cfg_type crc_cfg_o;
   logic        crc_hold = 1'b0;
   logic        burst_chk = 1'b0;
   logic [23:0] exp_addr = 24'h0;
   logic [23:0] last_addr = 24'h0;
   logic [31:0] q;
   int          error_cnt = 0;
   int          num_checks = 0;
   int          rd_cnt = 0;
   int          base = 0;
   int          cyc = 0;
   int          rd_cyc[$];

   always #2 clk_i = ~clk_i;

   crc_memory_scanner_debug_ctrl dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .dbg_evt_i(dbg_evt_i), .cpu_free_i(cpu_free_i),
      .cpu_stall_o(cpu_stall_o), .scan_frozen_o(scan_frozen_o),
      .trig_src_i(trig_src_i), .scanner_fuse_i(scanner_fuse_i),
      .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o),
      .mem_data_i(mem_data_i), .crc_ready_i(crc_ready_i),
      .crc_busy_i(crc_busy_i), .crc_shift_i(crc_shift_i),
      .crc_load_o(crc_load_o), .crc_data_o(crc_data_o),
      .crc_cfg_o(crc_cfg_o)
   );
   scan_partner #(.SHIFT_VAL(SHIFT_VAL)) partner_u (
      .clk_i(clk_i), .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o),
      .mem_data_o(mem_data_i), .crc_load_i(crc_load_o),
      .hold_i(crc_hold), .crc_ready_o(crc_ready_i),
      .crc_busy_o(crc_busy_i), .crc_shift_o(crc_shift_i)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string msg);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s %h/%h", $time, msg, seen, exp);
      end
   endtask

   task automatic summarize();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // watches flash reads and words handed to the checksum unit
   always @(posedge clk_i) begin
      cyc++;
      if (crc_load_o === 1'b1) begin
         check({16'h0, crc_data_o}, {16'h0, last_addr[15:0] ^ 16'ha5c3},
               "word");
      end
      if (mem_rd_o === 1'b1) begin
         check({8'h0, mem_addr_o}, {8'h0, exp_addr}, "addr");
         if (burst_chk && rd_cnt > base) begin
            check({31'h0, cpu_stall_o}, 32'h1, "stall");
         end
         last_addr = mem_addr_o;
         exp_addr = exp_addr + 24'h000002;
         rd_cnt++;
         rd_cyc.push_back(cyc);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic wb(input logic [11:0] idx, input logic we,
                     input logic [31:0] d, input logic [3:0] sel);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_adr_i <= {2'b00, idx, 2'b00};
      wb_we_i  <= we;
      wb_dat_i <= d;
      wb_sel_i <= sel;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 40);
      q = wb_dat_o;
      if (wb_ack_o !== 1'b1) begin
         check(32'h0, 32'h1, "no ack");
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask

   // one-cycle debug pulse, k = bit of the event struct
   task automatic ev(input int k);
      dbg_evt_i <= dbg_evt_type'(5'h01 << k);
      @(posedge clk_i);
      dbg_evt_i <= 5'h00;
   endtask

   task automatic wait_done();
      int n;
      n = 0;
      do begin
         wb(`IDX_SCAN_CTRL, 1'b0, 32'h0, 4'h1);
         n++;
      end while (q[`SC_RUN] !== 1'b0 && n < 200);
      check({31'h0, q[`SC_RUN]}, 32'h0, "run");
   endtask

   task automatic start(input logic [1:0] mode, input logic [23:0] a,
                        input int n, input logic [7:0] md);
      exp_addr = a;
      wb(`IDX_MOD_DISABLE, 1'b1, {24'h0, md}, 4'h1);
      wb(`IDX_CRC_CTRL0, 1'b1, 32'hc0, 4'h1);
      wb(`IDX_SCAN_START, 1'b1, {8'h0, a}, 4'h7);
      wb(`IDX_SCAN_END, 1'b1, {8'h0, a + 24'(2 * (n - 1))}, 4'h7);
      wb(`IDX_SCAN_TRIG, 1'b1, 32'h05, 4'h1);
      wb(`IDX_SCAN_CTRL, 1'b1, {24'h0, 6'h20, mode}, 4'h1);
      base = rd_cnt;
      wb(`IDX_SCAN_CTRL, 1'b1, {24'h0, 6'h30, mode}, 4'h1);
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic regs();
      wb(`IDX_SCAN_CTRL, 1'b0, 32'h0, 4'h1);
      check(q, 32'h10, "ctrl rst");
      wb(12'h100, 1'b1, 32'hffff_ffff, 4'hf);
      wb(12'h100, 1'b0, 32'h0, 4'hf);
      check(q, 32'h0, "unmapped");
      wb(`IDX_CRC_TAPS, 1'b1, 32'h0, 4'h3);
      wb(`IDX_CRC_TAPS, 1'b0, 32'h0, 4'h3);
      check(q, 32'h1, "taps");
      wb(`IDX_CRC_SHIFT, 1'b1, 32'h0, 4'h3);
      wb(`IDX_CRC_SHIFT, 1'b0, 32'h0, 4'h3);
      check(q, {16'h0, SHIFT_VAL}, "shifter");
   endtask

   // conc starts against a stalled checksum unit, peek without free slot
   task automatic run_mode(input scan_mode_type mode);
      cpu_free_i <= (mode != MODE_PEEK);
      crc_hold <= (mode == MODE_CONC);
      burst_chk = (mode == MODE_BURST);
      start(mode, 24'h000100, 3, 8'h00);
      trig_src_i <= 32'h10;
      repeat (8) @(posedge clk_i);
      if (mode != MODE_BURST) begin
         check(32'(rd_cnt - base), 32'h0, "early");
      end
      cpu_free_i <= 1'b1;
      crc_hold <= 1'b0;
      trig_src_i <= 32'h30;
      wait_done();
      burst_chk = 1'b0;
      check(32'(rd_cnt - base), 32'h3, "count");
      if (mode != MODE_PEEK) begin
         check(32'(rd_cyc[$] - rd_cyc[$-2]),
               32'((mode == MODE_BURST) ? 2 : 4), "spacing");
      end
      trig_src_i <= 32'h0;
   endtask

   // event arrives in the cycle after the run-bit write, with the first read out except in triggered mode
   task automatic run_evt(input logic [1:0] mode, input int k,
                          input int early);
      start(mode, 24'h000200, 4, 8'h00);
      ev(k);
      repeat (10) @(posedge clk_i);
      check({31'h0, scan_frozen_o}, 32'h1, "frozen");
      check(32'(rd_cnt - base), 32'(early), "halted reads");
      ev(0);
      // triggered mode needs its rising edge once the freeze is gone
      trig_src_i <= 32'h20;
      wait_done();
      trig_src_i <= 32'h0;
      check(32'(rd_cnt - base), 32'h4, "after exit");
   endtask

   task automatic mid_burst();
      logic [31:0] a1;
      int          n;
      start(MODE_BURST, 24'h000400, 8, 8'h00);
      n = 0;
      while (rd_cnt - base < 2 && n < 20) begin
         @(posedge clk_i);
         n++;
      end
      ev(4);
      repeat (3) @(posedge clk_i);
      n = rd_cnt;
      wb(`IDX_SCAN_START, 1'b0, 32'h0, 4'h7);
      a1 = q;
      check(a1, {8'h0, exp_addr}, "held addr");
      wb(`IDX_SCAN_CTRL, 1'b0, 32'h0, 4'h1);
      check({31'h0, q[`SC_RUN]}, 32'h1, "held run");
      repeat (10) @(posedge clk_i);
      wb(`IDX_SCAN_START, 1'b0, 32'h0, 4'h7);
      check(q, a1, "addr frozen");
      check(32'(rd_cnt), 32'(n), "progress");
      ev(0);
      wait_done();
      check(32'(rd_cnt - base), 32'h8, "resumed");
   endtask

   task automatic abort_scan();
      int n;
      start(MODE_CONC, 24'h000800, 8, 8'h00);
      repeat (5) @(posedge clk_i);
      wb(`IDX_SCAN_CTRL, 1'b1, 32'h0, 4'h1);
      // let a read issued in the clearing cycle be counted first
      @(posedge clk_i);
      n = rd_cnt;
      repeat (10) @(posedge clk_i);
      check(32'(rd_cnt), 32'(n), "abort");
      wb(`IDX_SCAN_CTRL, 1'b0, 32'h0, 4'h1);
      check(q, 32'h10, "ctrl clr");
   endtask

   task automatic disables();
      start(MODE_CONC, 24'h000600, 2, 8'h02);
      repeat (12) @(posedge clk_i);
      check(32'(rd_cnt - base), 32'h0, "scan off");
      wb(`IDX_SCAN_CTRL, 1'b1, 32'h0, 4'h1);
      wb(`IDX_MOD_DISABLE, 1'b1, 32'h1, 4'h1);
      // enable clears one edge after the off bit is stored
      @(posedge clk_i);
      check({31'h0, crc_cfg_o.en}, 32'h0, "crc off");
      scanner_fuse_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      start(MODE_CONC, 24'h000600, 2, 8'h00);
      repeat (12) @(posedge clk_i);
      check(32'(rd_cnt - base), 32'h0, "no fuse");
      wb(`IDX_SCAN_CTRL, 1'b1, 32'h0, 4'h1);
      scanner_fuse_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      start(MODE_CONC, 24'h000600, 2, 8'h00);
      wait_done();
      check(32'(rd_cnt - base), 32'h2, "fuse on");
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      regs();
      for (int m = 0; m < 4; m++) run_mode(scan_mode_type'(m));
      run_evt(MODE_BURST, 4, 1);
      run_evt(MODE_BURST, 3, 1);
      run_evt(MODE_BURST, 1, 2);
      run_evt(MODE_CONC, 2, 1);
      run_evt(MODE_CONC, 4, 1);
      run_evt(MODE_CONC, 1, 1);
      run_evt(MODE_TRIG, 3, 0);
      run_evt(MODE_PEEK, 3, 1);
      mid_burst();
      abort_scan();
      disables();
      summarize();
   end

   initial begin
      #80000;
      error_cnt++;
      summarize();
   end
endmodule
